/* File: hw/clt_pair_buf.sv */
// Small flop FIFO with valid/ready on both sides.
// Assumes one clock; out_data comes straight from the storage flops.
`include "clt_params.svh"

module clt_pair_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `CLT_BUF_DEPTH
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_ptr_q;
  logic [PW-1:0]    rd_ptr_q;
  logic [CW-1:0]    count_q;
  logic             push;
  logic             pop;

  function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
    next_ptr = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign in_ready  = (count_q != CW'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data  = mem_q[rd_ptr_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= next_ptr(wr_ptr_q);
      end
      if (pop) begin
        rd_ptr_q <= next_ptr(rd_ptr_q);
      end
    end
  end

  // Fill level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_q <= '0;
    end else if (push && !pop) begin
      count_q <= count_q + 1'b1;
    end else if (pop && !push) begin
      count_q <= count_q - 1'b1;
    end
  end

endmodule // clt_pair_buf

/* File: hw/clt_params.svh */
// Constants for the tap packer: widths, link positions, buffer depth.
// Assumes inclusion from the package and the design modules only.
`ifndef CLT_PARAMS_SVH
`define CLT_PARAMS_SVH

// Pixel and link widths, buffer depth
`define CLT_TAPS      8
`define CLT_TAP_W     10
`define CLT_PORT_W    8
`define CLT_CH_W      28
`define CLT_POS_W     5
`define CLT_BUF_DEPTH 2

// Serializer input positions of port bits 7..0, five bits per entry
`define CLT_POS_A {5'h05, 5'h1b, 5'h06, 5'h04, 5'h03, 5'h02, 5'h01, 5'h00}
`define CLT_POS_B {5'h0b, 5'h0a, 5'h0e, 5'h0d, 5'h0c, 5'h09, 5'h08, 5'h07}
`define CLT_POS_C {5'h11, 5'h10, 5'h16, 5'h15, 5'h14, 5'h13, 5'h12, 5'h0f}

// Qualifier and spare positions
`define CLT_TX_SPARE 5'h17
`define CLT_TX_LVAL  5'h18
`define CLT_TX_FVAL  5'h19
`define CLT_TX_DVAL  5'h1a

// Power-on configuration
`define CLT_MODE_RESET 2'h0

`endif

/* File: hw/clt_pkg.sv */
// Types shared by the tap packer modules.
// Assumes clt_params.svh is on the include path.
`include "clt_params.svh"

package clt_pkg;

  // Tap configurations
  typedef enum logic [1:0] {
    CLT_MODE_BASE   = 2'h0,
    CLT_MODE_MEDIUM = 2'h1,
    CLT_MODE_FULL   = 2'h2
  } clt_mode_t;

  // One pixel-clock word from the image pipeline
  typedef struct packed {
    logic [`CLT_TAPS-1:0][`CLT_TAP_W-1:0] tap;
    logic                                  lval;
    logic                                  fval;
  } clt_pix_t;

  // Serializer input words of the three channel links
  typedef struct packed {
    logic [`CLT_CH_W-1:0] x;
    logic [`CLT_CH_W-1:0] y;
    logic [`CLT_CH_W-1:0] z;
  } clt_link_t;

endpackage : clt_pkg

/* File: hw/clt_tap_packer.sv */
// Packs parallel pixel taps onto three channel-link serializer words.
// Assumes pixel words on ref_clk; link_clk arrives from outside.
`include "clt_params.svh"

module clt_tap_packer (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // Configuration
  input  wire clt_pkg::clt_mode_t mode,
  // Pixel stream
  input  wire logic              pix_valid,
  output logic                   pix_ready,
  input  wire clt_pkg::clt_pix_t pix_data,
  // Link
  input  wire logic              link_clk,
  output clt_pkg::clt_link_t     link_word,
  output logic                   link_stb
);

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry buffer in the data path

  logic              buf_valid;
  logic              buf_ready;
  clt_pkg::clt_pix_t buf_data;

  clt_pair_buf #(
    .WIDTH ($bits(clt_pkg::clt_pix_t)),
    .DEPTH (`CLT_BUF_DEPTH)
  ) u_buf (
    .clk       (ref_clk),
    .rst       (rst),
    .in_valid  (pix_valid),
    .in_ready  (pix_ready),
    .in_data   (pix_data),
    .out_valid (buf_valid),
    .out_ready (buf_ready),
    .out_data  (buf_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Link clock sampling and edge detection

  logic lc_s1_q;
  logic lc_s2_q;
  logic lc_s3_q;
  logic lc_seen_q;
  logic lc_rise;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lc_s1_q <= 1'b0;
      lc_s2_q <= 1'b0;
      lc_s3_q <= 1'b0;
    end else begin
      lc_s1_q <= link_clk;
      lc_s2_q <= lc_s1_q;
      lc_s3_q <= lc_s2_q;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lc_seen_q <= 1'b0;
    end else if (lc_s2_q == lc_s3_q) begin
      lc_seen_q <= lc_s2_q;
    end
  end

  assign lc_rise   = (lc_s2_q == lc_s3_q) && lc_s2_q && !lc_seen_q;
  assign buf_ready = lc_rise;

  ////////////////////////////////////////////////////////////////////////////
  // Packing functions

  // Place three ports and the qualifiers on one serializer word
  function automatic logic [`CLT_CH_W-1:0] pack_chan(
    input logic [`CLT_PORT_W-1:0] pa,
    input logic [`CLT_PORT_W-1:0] pb,
    input logic [`CLT_PORT_W-1:0] pc,
    input logic                   lv,
    input logic                   fv
  );
    logic [`CLT_CH_W-1:0]              tx;
    logic [`CLT_PORT_W*`CLT_POS_W-1:0] pos_a;
    logic [`CLT_PORT_W*`CLT_POS_W-1:0] pos_b;
    logic [`CLT_PORT_W*`CLT_POS_W-1:0] pos_c;
    tx    = '0;
    pos_a = `CLT_POS_A;
    pos_b = `CLT_POS_B;
    pos_c = `CLT_POS_C;
    for (int i = 0; i < `CLT_PORT_W; i++) begin
      tx[pos_a[i*`CLT_POS_W +: `CLT_POS_W]] = pa[i];
      tx[pos_b[i*`CLT_POS_W +: `CLT_POS_W]] = pb[i];
      tx[pos_c[i*`CLT_POS_W +: `CLT_POS_W]] = pc[i];
    end
    tx[`CLT_TX_LVAL]  = lv;
    tx[`CLT_TX_FVAL]  = fv;
    tx[`CLT_TX_DVAL]  = lv;
    tx[`CLT_TX_SPARE] = 1'b0;
    pack_chan = tx;
  endfunction

  // Upper two bits of two 10-bit taps share one port
  function automatic logic [`CLT_PORT_W-1:0] pack_msbs(
    input logic [`CLT_TAP_W-1:0] lo_tap,
    input logic [`CLT_TAP_W-1:0] hi_tap
  );
    pack_msbs = {2'h0, hi_tap[9:8], 2'h0, lo_tap[9:8]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Configuration held from frame start until an idle or frame-end link word

  clt_pkg::clt_mode_t mode_q;
  clt_pkg::clt_mode_t mode_sel;
  logic               in_frame;

  assign in_frame = link_word.x[`CLT_TX_FVAL];
  assign mode_sel = in_frame ? mode_q : mode;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode_q <= clt_pkg::clt_mode_t'(`CLT_MODE_RESET);
    end else if (lc_rise && !in_frame) begin
      mode_q <= mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Word assembly

  clt_pkg::clt_link_t word_d;

  always_comb begin
    word_d = '0;
    case (mode_sel)
      clt_pkg::CLT_MODE_BASE: begin
        word_d.x = pack_chan(buf_data.tap[0][7:0],
                             pack_msbs(buf_data.tap[0], buf_data.tap[1]),
                             buf_data.tap[1][7:0],
                             buf_data.lval, buf_data.fval);
      end
      clt_pkg::CLT_MODE_MEDIUM: begin
        word_d.x = pack_chan(buf_data.tap[0][7:0],
                             pack_msbs(buf_data.tap[0], buf_data.tap[1]),
                             buf_data.tap[1][7:0],
                             buf_data.lval, buf_data.fval);
        word_d.y = pack_chan(buf_data.tap[3][7:0],
                             buf_data.tap[2][7:0],
                             pack_msbs(buf_data.tap[2], buf_data.tap[3]),
                             buf_data.lval, buf_data.fval);
      end
      clt_pkg::CLT_MODE_FULL: begin
        word_d.x = pack_chan(buf_data.tap[0][7:0], buf_data.tap[1][7:0],
                             buf_data.tap[2][7:0],
                             buf_data.lval, buf_data.fval);
        word_d.y = pack_chan(buf_data.tap[3][7:0], buf_data.tap[4][7:0],
                             buf_data.tap[5][7:0],
                             buf_data.lval, buf_data.fval);
        word_d.z = pack_chan(buf_data.tap[6][7:0], buf_data.tap[7][7:0],
                             8'h00, buf_data.lval, buf_data.fval);
      end
      default: begin
        word_d = '0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output word, loaded on each link clock rise

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      link_word <= '0;
    end else if (lc_rise) begin
      link_word <= buf_valid ? word_d : '0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      link_stb <= 1'b0;
    end else begin
      link_stb <= lc_rise;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  spare_low_a: assert property (
    !link_word.x[`CLT_TX_SPARE] && !link_word.y[`CLT_TX_SPARE]
    && !link_word.z[`CLT_TX_SPARE])
    else $error("spare position driven high");

  dval_follows_a: assert property (
    link_word.x[`CLT_TX_DVAL] == link_word.x[`CLT_TX_LVAL]
    && link_word.y[`CLT_TX_DVAL] == link_word.y[`CLT_TX_LVAL])
    else $error("data valid differs from line valid");

  base_only_x_a: assert property (
    lc_rise && buf_valid && mode_sel == clt_pkg::CLT_MODE_BASE
    |=> link_word.y == '0 && link_word.z == '0
        && link_word.x[8] == $past(buf_data.tap[0][9])
        && link_word.x[14] == $past(buf_data.tap[1][9]))
    else $error("base layout wrong");

  base_lsb_a: assert property (
    lc_rise && buf_valid && mode_sel == clt_pkg::CLT_MODE_BASE
    |=> link_word.x[0] == $past(buf_data.tap[0][0])
        && link_word.x[15] == $past(buf_data.tap[1][0])
        && link_word.x[9] == 1'b0)
    else $error("base tap bit order wrong");

  medium_pack_a: assert property (
    lc_rise && buf_valid && mode_sel == clt_pkg::CLT_MODE_MEDIUM
    |=> link_word.z == '0
        && link_word.y[22] == $past(buf_data.tap[3][9])
        && link_word.y[7] == $past(buf_data.tap[2][0]))
    else $error("medium layout wrong");

  port_map_a: assert property (
    lc_rise && buf_valid && mode_sel == clt_pkg::CLT_MODE_FULL
    |=> link_word.x[27] == $past(buf_data.tap[0][6])
        && link_word.x[10] == $past(buf_data.tap[1][6])
        && link_word.y[17] == $past(buf_data.tap[5][7]))
    else $error("serializer position wrong");

  full_msb_a: assert property (
    lc_rise && buf_valid && mode_sel == clt_pkg::CLT_MODE_FULL
    |=> link_word.x[5] == $past(buf_data.tap[0][7])
        && link_word.z[7] == $past(buf_data.tap[7][0]))
    else $error("full tap bit order wrong");

  full_zc_low_a: assert property (
    lc_rise && buf_valid && mode_sel == clt_pkg::CLT_MODE_FULL
    |=> {link_word.z[22:18], link_word.z[17:15]} == 8'h00)
    else $error("channel z port c not low");

  full_qual_a: assert property (
    lc_rise && buf_valid && mode_sel == clt_pkg::CLT_MODE_FULL
    |=> link_word.z[`CLT_TX_FVAL] == link_word.x[`CLT_TX_FVAL]
        && link_word.z[`CLT_TX_DVAL] == $past(buf_data.lval))
    else $error("full mode qualifiers wrong");

  frame_mode_a: assert property (
    in_frame && lc_rise |=> $stable(mode_q))
    else $error("configuration changed inside a frame");

  idle_zero_a: assert property (
    lc_rise && !buf_valid |=> link_word == '0)
    else $error("idle link word not low");

  base_unused_a: assert property (
    lc_rise && buf_valid && mode_sel == clt_pkg::CLT_MODE_BASE
    |=> {link_word.x[12:9], link_word.x[`CLT_TX_SPARE]} == 5'h00
        && link_word.x[7] == $past(buf_data.tap[0][8])
        && link_word.x[13] == $past(buf_data.tap[1][8]))
    else $error("base unused bits not low");

  medium_unused_a: assert property (
    lc_rise && buf_valid && mode_sel == clt_pkg::CLT_MODE_MEDIUM
    |=> link_word.x[12:9] == 4'h0
        && {link_word.y[20:19], link_word.y[17:16]} == 4'h0
        && link_word.y[15] == $past(buf_data.tap[2][8])
        && link_word.y[0] == $past(buf_data.tap[3][0]))
    else $error("medium unused bits not low");

  full_yz_a: assert property (
    lc_rise && buf_valid && mode_sel == clt_pkg::CLT_MODE_FULL
    |=> link_word.y[0] == $past(buf_data.tap[3][0])
        && link_word.y[7] == $past(buf_data.tap[4][0])
        && link_word.y[15] == $past(buf_data.tap[5][0])
        && link_word.z[0] == $past(buf_data.tap[6][0]))
    else $error("full taps on y or z misplaced");

  full_qual_y_a: assert property (
    lc_rise && buf_valid && mode_sel == clt_pkg::CLT_MODE_FULL
    |=> link_word.y[`CLT_TX_LVAL] == $past(buf_data.lval)
        && link_word.y[`CLT_TX_FVAL] == $past(buf_data.fval)
        && link_word.y[`CLT_TX_DVAL] == $past(buf_data.lval)
        && link_word.x[`CLT_TX_DVAL] == $past(buf_data.lval))
    else $error("full mode qualifiers on y wrong");

  mode_off_a: assert property (
    lc_rise && !(mode_sel inside {clt_pkg::CLT_MODE_BASE,
                                  clt_pkg::CLT_MODE_MEDIUM,
                                  clt_pkg::CLT_MODE_FULL})
    |=> link_word == '0)
    else $error("unused mode word not low");

endmodule // clt_tap_packer

/* File: test/clt_grabber_model.sv */
// Frame grabber model: makes the link clock, unpacks in-frame words.
// Assumes link_word and link_stb come from the packer on ref_clk.
module clt_grabber_model (
  // Pixel-side clock
  input  wire logic               ref_clk,
  // Link from the packer
  input  wire clt_pkg::clt_link_t link_word,
  input  wire logic               link_stb,
  // Link clock and unpacked ports
  output logic                    link_clk,
  output logic [2:0][2:0][7:0]    rx_port
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int P[3][8] = '{'{0, 1, 2, 3, 4, 6, 27, 5},
                             '{7, 8, 9, 12, 13, 14, 10, 11},
                             '{15, 18, 19, 20, 21, 22, 16, 17}};
  logic [2:0][27:0] ch;
  assign ch = {link_word.x, link_word.y, link_word.z};
  ////////////////////////////////////////////////////////////////////////
  // Free-running link clock, phase unrelated to ref_clk
  initial begin
    link_clk = 1'b0;
    #37;
    forever #80 link_clk = ~link_clk;
  end
  ////////////////////////////////////////////////////////////////////////
  // Unpack words whose frame flag is set; idle words are ignored
  always_ff @(posedge ref_clk) begin
    if (link_stb && link_word.x[25]) begin
      for (int c = 0; c < 3; c++) begin
        for (int p = 0; p < 3; p++) begin
          for (int i = 0; i < 8; i++) begin
            rx_port[c][p][i] <= ch[2-c][P[p][i]];
          end
        end
      end
    end
  end
endmodule // clt_grabber_model

/* File: test/testbench.sv */
// Self-checking bench for the tap packer in all three layouts.
// Assumes the grabber model makes link_clk at 160 ns.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int P[3][8] = '{'{0, 1, 2, 3, 4, 6, 27, 5},
                             '{7, 8, 9, 12, 13, 14, 10, 11},
                             '{15, 18, 19, 20, 21, 22, 16, 17}};
  logic               ref_clk = 1'b0;
  logic               rst = 1'b1;
  logic               pix_valid = 1'b0;
  logic               pix_ready;
  logic               link_clk;
  logic               link_stb;
  clt_pkg::clt_mode_t mode = clt_pkg::CLT_MODE_BASE;
  clt_pkg::clt_pix_t  pix_data = '0;
  clt_pkg::clt_link_t link_word;
  clt_pkg::clt_link_t q[$];
  logic [2:0][2:0][7:0] rx_port;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;

  clt_tap_packer DUT (.ref_clk(ref_clk), .rst(rst), .mode(mode),
    .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_data(pix_data),
    .link_clk(link_clk), .link_word(link_word), .link_stb(link_stb));
  clt_grabber_model grabber (.ref_clk(ref_clk), .link_word(link_word),
    .link_stb(link_stb), .link_clk(link_clk), .rx_port(rx_port));

  always #5 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////
  // Collect non-idle link words; cut a hang short
  always @(posedge ref_clk) begin
    if (link_stb === 1'b1 && link_word !== '0) q.push_back(link_word);
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(string n, logic [83:0] s, logic [83:0] e);
    total_checks++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask

  function automatic clt_pkg::clt_pix_t mk(int s, logic lv, logic fv);
    clt_pkg::clt_pix_t p;
    for (int i = 0; i < 8; i++) p.tap[i] = 10'(s * 167 + i * 301 + 83);
    p.lval = lv;
    p.fval = fv;
    return p;
  endfunction

  function automatic logic [27:0] chan(logic [7:0] a, logic [7:0] b,
                                       logic [7:0] c, logic lv, logic fv);
    logic [27:0] w;
    w = '0;
    for (int i = 0; i < 8; i++) begin
      w[P[0][i]] = a[i];
      w[P[1][i]] = b[i];
      w[P[2][i]] = c[i];
    end
    w[24] = lv;
    w[25] = fv;
    w[26] = lv;
    return w;
  endfunction

  function automatic clt_pkg::clt_link_t pack(clt_pkg::clt_mode_t m,
                                              clt_pkg::clt_pix_t p);
    clt_pkg::clt_link_t r;
    logic [7:0][9:0]    t;
    t = p.tap;
    r = '0;
    if (m != clt_pkg::CLT_MODE_FULL)
      r.x = chan(t[0][7:0], {2'h0, t[1][9:8], 2'h0, t[0][9:8]},
                 t[1][7:0], p.lval, p.fval);
    if (m == clt_pkg::CLT_MODE_MEDIUM)
      r.y = chan(t[3][7:0], t[2][7:0],
                 {2'h0, t[3][9:8], 2'h0, t[2][9:8]}, p.lval, p.fval);
    if (m == clt_pkg::CLT_MODE_FULL) begin
      r.x = chan(t[0][7:0], t[1][7:0], t[2][7:0], p.lval, p.fval);
      r.y = chan(t[3][7:0], t[4][7:0], t[5][7:0], p.lval, p.fval);
      r.z = chan(t[6][7:0], t[7][7:0], 8'h00, p.lval, p.fval);
    end
    return r;
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // Offer a word and hold it until taken; valid stays up
  task automatic send(clt_pkg::clt_pix_t w);
    pix_data <= w;
    pix_valid <= 1'b1;
    for (int k = 0; k < 200; k++) begin
      @(posedge ref_clk);
      if (pix_ready === 1'b1) break;
    end
  endtask

  task automatic get(clt_pkg::clt_link_t e);
    clt_pkg::clt_link_t s;
    s = 'x;
    for (int k = 0; k < 100 && q.size() == 0; k++) @(posedge ref_clk);
    if (q.size() > 0) s = q.pop_front();
    check("link_word", s, e);
  endtask

  task automatic xfer(clt_pkg::clt_mode_t m, clt_pkg::clt_pix_t w);
    send(w);
    pix_valid <= 1'b0;
    get(pack(m, w));
  endtask

  task automatic set_mode(clt_pkg::clt_mode_t m);
    mode <= m;
    repeat (80) @(posedge ref_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_base();
    set_mode(clt_pkg::CLT_MODE_BASE);
    for (int i = 0; i < 3; i++)
      xfer(clt_pkg::CLT_MODE_BASE, mk(i, i != 1, 1'b1));
  endtask

  task automatic t_medium();
    set_mode(clt_pkg::CLT_MODE_MEDIUM);
    for (int i = 0; i < 3; i++)
      xfer(clt_pkg::CLT_MODE_MEDIUM, mk(i + 3, i != 0, 1'b1));
  endtask

  task automatic t_full();
    clt_pkg::clt_pix_t w;
    set_mode(clt_pkg::CLT_MODE_FULL);
    for (int i = 0; i < 3; i++) begin
      w = mk(i + 9, i != 2, 1'b1);
      xfer(clt_pkg::CLT_MODE_FULL, w);
      @(posedge ref_clk);
      for (int k = 0; k < 8; k++)
        check("rx tap", 84'(rx_port[k/3][k%3]), 84'(w.tap[k][7:0]));
    end
  endtask

  task automatic t_stall();
    clt_pkg::clt_pix_t w[3];
    for (int i = 0; i < 3; i++) w[i] = mk(i + 6, 1'b1, 1'b1);
    @(posedge link_stb);
    @(posedge ref_clk);
    send(w[0]);
    send(w[1]);
    pix_data <= w[2];
    @(posedge ref_clk);
    check("pix_ready full", 84'(pix_ready), 84'h0);
    send(w[2]);
    pix_valid <= 1'b0;
    for (int i = 0; i < 3; i++) get(pack(clt_pkg::CLT_MODE_MEDIUM, w[i]));
    repeat (40) @(posedge ref_clk);
    check("pix_ready empty", 84'(pix_ready), 84'h1);
  endtask

  task automatic t_off();
    set_mode(clt_pkg::clt_mode_t'(2'h3));
    send(mk(30, 1'b1, 1'b1));
    send(mk(31, 1'b1, 1'b1));
    pix_valid <= 1'b0;
    repeat (40) @(posedge ref_clk);
    check("off words", 84'(q.size()), 84'h0);
    check("off drained", 84'(pix_ready), 84'h1);
  endtask

  task automatic t_frame();
    set_mode(clt_pkg::CLT_MODE_BASE);
    xfer(clt_pkg::CLT_MODE_BASE, mk(20, 1'b1, 1'b1));
    mode <= clt_pkg::CLT_MODE_FULL;
    xfer(clt_pkg::CLT_MODE_BASE, mk(21, 1'b1, 1'b1));
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    check("reset word", 84'(link_word), 84'h0);
    check("reset ready", 84'(pix_ready), 84'h1);
    t_base();
    t_medium();
    t_stall();
    t_frame();
    t_off();
    t_full();
    give_verdict();
  end
endmodule // testbench
